/* File: trigger_delay_cfg.svh */
/*
 * Register map, field positions, reset values and timing constants for the
 * trigger delay block, plus the list of what the block does.
 * Assumes it is included by the package and the testbench by bare name.
 */
// What this block does
// [R1] repeat_enable 0 gives one-shot, 1 restarts counting after each wrap
// [R2] with source 111 and block enabled, writing soft_fire restarts the counter
// [R3] delay A and B set trigger delays while enabled and not bypassed
// [R4] counter spans 0x0001..0xFFFF, so delay 0x0000 never matches
// [R5] at modulus the counter reloads to one; runs on only in repeat mode
// [R6] counter is 16 bits, read through count_high and count_low bytes
// [R7] reading one count byte latches both; the other byte returns the latched half
// [R8] pin_drive_enable routes the pulse output to the pad
// [R9] block_enable 0 stops the counter and forces all fire outputs low
// [R10] wrap_flag sets on modulus match, cleared by writing one
// [R11] wrap_request_enable gates the wrap request output
// [R12] second_match_flag sets on delay B match, cleared by writing one
// [R13] second_match_request_enable gates the delay B request output
// [R14] first_match_flag sets on delay A match, cleared by writing one
// [R15] first_match_request_enable gates the delay A request output
// [R16] fire outputs come straight from flip-flops, so never glitch
// [R17] every new trigger restarts the counter even mid-count
// [R18] prescale N advances the counter once per N clocks
// [R19] one synchronous reset returns every register to its reset value
// [R20] one clock drives everything; prescale enable is derived from it
// [R21] timing registers double-buffered; load_request transfers per load_timing_select
// [R22] early fire at prescale*delay+1 clocks, fire out one clock later
// [R23] out source 00 bypass, 01 own delay, 10 both delays, 11 pulse
// [R24] 3-bit prescale divides by 1 at 000 up to 128 at 111
// [R25] selected trigger input is synchronised and its rising edge is an event
// [R26] pulse output rises at delay A match and falls at delay B match
`ifndef TRIGGER_DELAY_CFG_SVH
`define TRIGGER_DELAY_CFG_SVH

// ----------------------------------------------------------------------
// register byte addresses (printed offsets are indices, address = 4*index)
// ----------------------------------------------------------------------
`define TD_IDX_SETUP_ONE   4'h0
`define TD_IDX_SETUP_TWO   4'h1
`define TD_IDX_DLY_A_HIGH  4'h2
`define TD_IDX_DLY_A_LOW   4'h3
`define TD_IDX_DLY_B_HIGH  4'h4
`define TD_IDX_DLY_B_LOW   4'h5
`define TD_IDX_PERIOD_HIGH 4'h6
`define TD_IDX_PERIOD_LOW  4'h7
`define TD_IDX_COUNT_HIGH  4'h8
`define TD_IDX_COUNT_LOW   4'h9
`define TD_IDX_STATE_EN    4'hA

// ----------------------------------------------------------------------
// trig_setup_one fields
// ----------------------------------------------------------------------
`define TD_S1_LOAD_SEL  7
`define TD_S1_BSRC_HI   6
`define TD_S1_BSRC_LO   5
`define TD_S1_B_EN      4
`define TD_S1_ASRC_HI   3
`define TD_S1_ASRC_LO   2
`define TD_S1_A_EN      1
`define TD_S1_LOAD_REQ  0

// ----------------------------------------------------------------------
// trig_setup_two fields
// ----------------------------------------------------------------------
`define TD_S2_PRE_HI    7
`define TD_S2_PRE_LO    5
`define TD_S2_SRC_HI    4
`define TD_S2_SRC_LO    2
`define TD_S2_REPEAT    1
`define TD_S2_SOFT_FIRE 0

// ----------------------------------------------------------------------
// state_and_enable fields
// ----------------------------------------------------------------------
`define TD_SE_PIN_EN    7
`define TD_SE_BLOCK_EN  6
`define TD_SE_WRAP_F    5
`define TD_SE_WRAP_IE   4
`define TD_SE_SEC_F     3
`define TD_SE_SEC_IE    2
`define TD_SE_FIRST_F   1
`define TD_SE_FIRST_IE  0

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define TD_RST_BYTE     8'h00
`define TD_RST_WORD     16'h0000
`define TD_RST_PERIOD   16'hFFFF
`define TD_COUNT_START  16'h0001
`define TD_SRC_SOFT     3'b111

`endif

/* File: trigger_delay_pkg.sv */
/*
 * Types shared by the trigger delay block.
 * Assumes the constants header sits in the same folder.
 */
package trigger_delay_pkg;
`include "trigger_delay_cfg.svh"

	// output source selection of each fire output
	typedef enum logic [1:0]
	{
		SRC_BYPASS = 2'b00,
		SRC_OWN    = 2'b01,
		SRC_BOTH   = 2'b10,
		SRC_PULSE  = 2'b11
	} out_source_t;

	// counter run state
	typedef enum logic [0:0]
	{
		CNT_IDLE = 1'b0,
		CNT_RUN  = 1'b1
	} run_state_t;

endpackage

/* File: trigger_delay_block.sv */
/*
 * Programmable trigger delay block: APB register slave, prescaled 16-bit
 * counter, delay A/B compares, early and delayed fire outputs, pulse output.
 * Assumes one 40 MHz clock, synchronous active-high reset, trigger inputs
 * arriving asynchronously, and an APB master with 32-bit data.
 */
`timescale 1ns/100ps
module trigger_delay_block
	import trigger_delay_pkg::*;
#(
	parameter int TRIG_INPUTS = 7
)
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [TRIG_INPUTS-1:0] fireInput,
	output logic                        earlyFireA,
	output logic                        earlyFireB,
	output logic                        fireOutA,
	output logic                        fireOutB,
	output logic                        pulsePinOut,
	output logic                        pulsePinOe,
	output logic                        wrapRequest,
	output logic                        firstMatchRequest,
	output logic                        secondMatchRequest
);

	// ----------------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------------
	if (TRIG_INPUTS < 1 || TRIG_INPUTS > 7)
	begin : gBadInputs
		$error("trigger input count must be 1 to 7");
	end

	// ----------------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------------
	// word index from a byte address; out of range gives all ones
	function automatic logic [3:0] regIndex(input logic [11:0] addr);
		if (addr[11:6] != 6'h00 || addr[1:0] != 2'b00)
		begin
			return 4'hF;
		end
		return addr[5:2];
	endfunction

	// fire decision for one output, by source select
	function automatic logic fireSelect(input out_source_t src, input logic own,
		input logic both, input logic pulse, input logic bypass);
		unique case (src)
			SRC_BYPASS: return bypass;
			SRC_OWN:    return own;
			SRC_BOTH:   return both;
			SRC_PULSE:  return pulse;
		endcase
	endfunction

	// ----------------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------------
	logic [7:0]          setupOne_reg;
	logic [7:0]          setupTwo_reg;
	logic [7:0]          stateEn_reg;
	logic [15:0]         delayA_reg;
	logic [15:0]         delayB_reg;
	logic [15:0]         period_reg;
	logic [15:0]         delayAAct_reg;
	logic [15:0]         delayBAct_reg;
	logic [15:0]         periodAct_reg;
	logic [15:0]         count_reg;
	logic [15:0]         countHeld_reg;
	logic                countLatched_reg;
	logic [6:0]          prescale_reg;
	run_state_t          run_reg;
	logic [TRIG_INPUTS-1:0] trigMeta_reg;
	logic [TRIG_INPUTS-1:0] trigSync_reg;
	logic                trigLast_reg;
	logic                pulse_reg;

	// ----------------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------------
	logic [3:0]  idx;
	logic        wrAccess;
	logic        rdAccess;
	logic        mapped;
	logic        byteWr;
	logic [7:0]  wByte;

	assign idx      = regIndex(paddr);
	assign mapped   = idx <= `TD_IDX_STATE_EN;
	assign wrAccess = psel && penable && pwrite && mapped;
	assign rdAccess = psel && !penable && !pwrite && mapped;
	assign byteWr   = wrAccess && pstrb[0];
	assign wByte    = pwdata[7:0];

	// ----------------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------------
	logic        blockEn;
	logic        repeatEn;
	logic        loadPending;
	logic [2:0]  preSel;
	logic [2:0]  srcSel;
	out_source_t srcA;
	out_source_t srcB;

	assign blockEn     = stateEn_reg[`TD_SE_BLOCK_EN];
	assign repeatEn    = setupTwo_reg[`TD_S2_REPEAT];
	assign loadPending = setupOne_reg[`TD_S1_LOAD_REQ];
	assign preSel      = setupTwo_reg[`TD_S2_PRE_HI:`TD_S2_PRE_LO];
	assign srcSel      = setupTwo_reg[`TD_S2_SRC_HI:`TD_S2_SRC_LO];
	assign srcA        = out_source_t'(setupOne_reg[`TD_S1_ASRC_HI:`TD_S1_ASRC_LO]);
	assign srcB        = out_source_t'(setupOne_reg[`TD_S1_BSRC_HI:`TD_S1_BSRC_LO]);

	// ----------------------------------------------------------------------
	// trigger input synchroniser and edge detect
	// ----------------------------------------------------------------------
	// two flops per trigger input before any use
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			trigMeta_reg <= '0;
			trigSync_reg <= '0;
		end
		else
		begin
			trigMeta_reg <= fireInput;
			trigSync_reg <= trigMeta_reg;
		end
	end

	logic hwTrig;
	logic softFire;
	logic trigEvent;

	assign hwTrig = (srcSel < TRIG_INPUTS[2:0]) ? trigSync_reg[srcSel] : 1'b0;

	// previous level of the selected trigger
	always_ff @(posedge clk)
	begin
		if (rst)
			trigLast_reg <= 1'b0;
		else
			trigLast_reg <= hwTrig;
	end

	assign softFire  = byteWr && idx == `TD_IDX_SETUP_TWO && wByte[`TD_S2_SOFT_FIRE]
		&& srcSel == `TD_SRC_SOFT; // [R2]
	assign trigEvent = blockEn && (softFire || (hwTrig && !trigLast_reg)); // [R25] [R17]

	// ----------------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------------
	logic       tick;
	logic       atPeriod;
	logic       matchA;
	logic       matchB;
	logic [6:0] preMask;

	assign preMask  = 7'(({4'b0000, 3'b001} << preSel) - 7'h01); // [R24]
	assign tick     = (prescale_reg & preMask) == preMask; // [R18]
	assign atPeriod = run_reg == CNT_RUN && tick && count_reg == periodAct_reg;
	assign matchA   = run_reg == CNT_RUN && tick && count_reg == delayAAct_reg; // [R4]
	assign matchB   = run_reg == CNT_RUN && tick && count_reg == delayBAct_reg;

	// prescale divider, restarted by each trigger
	always_ff @(posedge clk)
	begin
		if (rst || trigEvent || run_reg == CNT_IDLE)
			prescale_reg <= 7'h00;
		else
			prescale_reg <= prescale_reg + 7'h01; // [R20]
	end

	// counter: 1..modulus, reload to one, repeat or stop
	always_ff @(posedge clk)
	begin
		if (rst || !blockEn)
		begin
			count_reg <= `TD_COUNT_START; // [R9]
			run_reg   <= CNT_IDLE;
		end
		else if (trigEvent)
		begin
			count_reg <= `TD_COUNT_START; // [R17]
			run_reg   <= CNT_RUN;
		end
		else if (atPeriod)
		begin
			count_reg <= `TD_COUNT_START; // [R5]
			run_reg   <= repeatEn ? CNT_RUN : CNT_IDLE; // [R1]
		end
		else if (run_reg == CNT_RUN && tick)
			count_reg <= count_reg + 16'h0001; // [R6]
	end

	// ----------------------------------------------------------------------
	// double-buffered timing values
	// ----------------------------------------------------------------------
	logic loadNow;
	logic reqWrite;

	assign reqWrite = byteWr && idx == `TD_IDX_SETUP_ONE && wByte[`TD_S1_LOAD_REQ];
	assign loadNow  = loadPending && (!setupOne_reg[`TD_S1_LOAD_SEL]
		|| (repeatEn ? atPeriod : trigEvent)); // [R21]

	// staging registers; ignored while a load is pending
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			delayA_reg <= `TD_RST_WORD;
			delayB_reg <= `TD_RST_WORD;
			period_reg <= `TD_RST_PERIOD;
		end
		else if (byteWr && !loadPending) // [R21]
		begin
			if (idx == `TD_IDX_DLY_A_HIGH)  delayA_reg[15:8] <= wByte;
			if (idx == `TD_IDX_DLY_A_LOW)   delayA_reg[7:0]  <= wByte;
			if (idx == `TD_IDX_DLY_B_HIGH)  delayB_reg[15:8] <= wByte;
			if (idx == `TD_IDX_DLY_B_LOW)   delayB_reg[7:0]  <= wByte;
			if (idx == `TD_IDX_PERIOD_HIGH) period_reg[15:8] <= wByte;
			if (idx == `TD_IDX_PERIOD_LOW)  period_reg[7:0]  <= wByte;
		end
	end

	// active copies used by the compares
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			delayAAct_reg <= `TD_RST_WORD;
			delayBAct_reg <= `TD_RST_WORD;
			periodAct_reg <= `TD_RST_PERIOD;
		end
		else if (loadNow)
		begin
			delayAAct_reg <= delayA_reg; // [R3]
			delayBAct_reg <= delayB_reg;
			periodAct_reg <= period_reg;
		end
	end

	// ----------------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------------
	// setup one: load request sets on write of one, clears on transfer
	always_ff @(posedge clk)
	begin
		if (rst)
			setupOne_reg <= `TD_RST_BYTE;
		else
		begin
			if (byteWr && idx == `TD_IDX_SETUP_ONE)
				setupOne_reg[7:1] <= wByte[7:1];
			if (reqWrite)
				setupOne_reg[`TD_S1_LOAD_REQ] <= 1'b1;
			else if (loadNow)
				setupOne_reg[`TD_S1_LOAD_REQ] <= 1'b0; // [R21]
		end
	end

	// setup two: soft fire bit is write-only, reads zero
	always_ff @(posedge clk)
	begin
		if (rst)
			setupTwo_reg <= `TD_RST_BYTE;
		else if (byteWr && idx == `TD_IDX_SETUP_TWO)
			setupTwo_reg <= {wByte[7:1], 1'b0};
	end

	// state/enable: flags set by hardware win over write-one-to-clear
	always_ff @(posedge clk)
	begin
		if (rst)
			stateEn_reg <= `TD_RST_BYTE;
		else
		begin
			if (byteWr && idx == `TD_IDX_STATE_EN)
			begin
				stateEn_reg[`TD_SE_PIN_EN]   <= wByte[`TD_SE_PIN_EN];
				stateEn_reg[`TD_SE_BLOCK_EN] <= wByte[`TD_SE_BLOCK_EN];
				stateEn_reg[`TD_SE_WRAP_IE]  <= wByte[`TD_SE_WRAP_IE];
				stateEn_reg[`TD_SE_SEC_IE]   <= wByte[`TD_SE_SEC_IE];
				stateEn_reg[`TD_SE_FIRST_IE] <= wByte[`TD_SE_FIRST_IE];
				if (wByte[`TD_SE_WRAP_F])  stateEn_reg[`TD_SE_WRAP_F]  <= 1'b0;
				if (wByte[`TD_SE_SEC_F])   stateEn_reg[`TD_SE_SEC_F]   <= 1'b0;
				if (wByte[`TD_SE_FIRST_F]) stateEn_reg[`TD_SE_FIRST_F] <= 1'b0;
			end
			if (atPeriod) stateEn_reg[`TD_SE_WRAP_F]  <= 1'b1; // [R10]
			if (matchB)   stateEn_reg[`TD_SE_SEC_F]   <= 1'b1; // [R12]
			if (matchA)   stateEn_reg[`TD_SE_FIRST_F] <= 1'b1; // [R14]
		end
	end

	// ----------------------------------------------------------------------
	// counter byte readback latch
	// ----------------------------------------------------------------------
	logic cntRead;

	assign cntRead = rdAccess && (idx == `TD_IDX_COUNT_HIGH || idx == `TD_IDX_COUNT_LOW);

	// odd reads capture, even reads return the held value
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			countHeld_reg    <= `TD_RST_WORD;
			countLatched_reg <= 1'b0;
		end
		else if (cntRead)
		begin
			if (!countLatched_reg)
				countHeld_reg <= count_reg; // [R7]
			countLatched_reg <= !countLatched_reg;
		end
	end

	// ----------------------------------------------------------------------
	// apb read mux and response
	// ----------------------------------------------------------------------
	logic [15:0] cntView;
	logic [7:0]  rByte;

	assign cntView = countLatched_reg ? countHeld_reg : count_reg;

	// byte selected by the access index
	always_comb
	begin
		unique case (idx)
			`TD_IDX_SETUP_ONE:   rByte = setupOne_reg;
			`TD_IDX_SETUP_TWO:   rByte = setupTwo_reg;
			`TD_IDX_DLY_A_HIGH:  rByte = delayA_reg[15:8];
			`TD_IDX_DLY_A_LOW:   rByte = delayA_reg[7:0];
			`TD_IDX_DLY_B_HIGH:  rByte = delayB_reg[15:8];
			`TD_IDX_DLY_B_LOW:   rByte = delayB_reg[7:0];
			`TD_IDX_PERIOD_HIGH: rByte = period_reg[15:8];
			`TD_IDX_PERIOD_LOW:  rByte = period_reg[7:0];
			`TD_IDX_COUNT_HIGH:  rByte = cntView[15:8]; // [R6]
			`TD_IDX_COUNT_LOW:   rByte = cntView[7:0];
			`TD_IDX_STATE_EN:    rByte = stateEn_reg;
			default:             rByte = `TD_RST_BYTE;
		endcase
	end

	// registered response, ready in the first access cycle, no wait state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && regIndex(paddr) > `TD_IDX_STATE_EN;
			prdata  <= (psel && !penable && !pwrite) ?
				{24'h00_0000, rByteSetup(paddr)} : 32'h0000_0000;
		end
	end

	// read data prepared in the setup cycle from the setup address
	function automatic logic [7:0] rByteSetup(input logic [11:0] addr);
		return (regIndex(addr) == idx) ? rByte : `TD_RST_BYTE;
	endfunction

	// ----------------------------------------------------------------------
	// fire outputs, pulse and requests
	// ----------------------------------------------------------------------
	logic fireA;
	logic fireB;

	// pulse high from delay A match until delay B match
	always_ff @(posedge clk)
	begin
		if (rst || !blockEn || trigEvent)
			pulse_reg <= 1'b0;
		else if (matchA)
			pulse_reg <= 1'b1; // [R26]
		else if (matchB)
			pulse_reg <= 1'b0;
	end

	assign fireA = setupOne_reg[`TD_S1_A_EN] && fireSelect(srcA, matchA, matchA || matchB,
		pulse_reg, trigEvent); // [R23]
	assign fireB = setupOne_reg[`TD_S1_B_EN] && fireSelect(srcB, matchB, matchA || matchB,
		pulse_reg, trigEvent);

	// early fire one clock ahead of fire out, all from flops
	always_ff @(posedge clk)
	begin
		if (rst || !blockEn)
		begin
			earlyFireA <= 1'b0; // [R9]
			earlyFireB <= 1'b0;
			fireOutA   <= 1'b0;
			fireOutB   <= 1'b0;
		end
		else
		begin
			earlyFireA <= fireA; // [R22]
			earlyFireB <= fireB;
			fireOutA   <= earlyFireA; // [R16]
			fireOutB   <= earlyFireB;
		end
	end

	// pad drive and gated requests
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pulsePinOut        <= 1'b0;
			pulsePinOe         <= 1'b0;
			wrapRequest        <= 1'b0;
			firstMatchRequest  <= 1'b0;
			secondMatchRequest <= 1'b0;
		end
		else
		begin
			pulsePinOut        <= pulse_reg;
			pulsePinOe         <= stateEn_reg[`TD_SE_PIN_EN]; // [R8]
			wrapRequest        <= stateEn_reg[`TD_SE_WRAP_F] && stateEn_reg[`TD_SE_WRAP_IE]; // [R11]
			secondMatchRequest <= stateEn_reg[`TD_SE_SEC_F] && stateEn_reg[`TD_SE_SEC_IE]; // [R13]
			firstMatchRequest  <= stateEn_reg[`TD_SE_FIRST_F]
				&& stateEn_reg[`TD_SE_FIRST_IE]; // [R15]
		end
	end

	// [R19] every flop above resets synchronously on rst

endmodule // trigger_delay_block

/* File: trigger_delay_asserts.sv */
/*
 * Port checker for the trigger delay block.
 * Assumes it is bound into trigger_delay_block, one clock, reset active high.
 */
`timescale 1ns/100ps
module trigger_delay_asserts
	import trigger_delay_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        earlyFireA,
	input wire logic        earlyFireB,
	input wire logic        fireOutA,
	input wire logic        fireOutB,
	input wire logic        pulsePinOe,
	input wire logic        wrapRequest,
	input wire logic        firstMatchRequest,
	input wire logic        secondMatchRequest
);
	logic scrWr;
	// access-phase write of state_and_enable
	assign scrWr = psel && penable && pwrite && pstrb[0] && paddr == 12'h028;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// answer one cycle after setup, error only off the map
	chk_apb_answer: assert property (psel && !penable |=> pready && pslverr == (paddr > 12'h028))
		else $error("apb answer wrong");
	chk_fire_a_lag: assert property (earlyFireA |=> fireOutA || $past(scrWr && !pwdata[6], 2))
		else $error("fire out A not one clock after early A");
	chk_fire_b_clean: assert property ($rose(fireOutB) |-> $past(earlyFireB))
		else $error("fire out B rose without early B");
	chk_pad_enable: assert property (scrWr |=> ##1 pulsePinOe == $past(pwdata[7], 2))
		else $error("pad enable does not follow bit 7");
	chk_wrap_gate: assert property (scrWr && !pwdata[4] |=> ##1 !wrapRequest)
		else $error("wrap request while disabled");
	chk_second_gate: assert property (scrWr && !pwdata[2] |=> ##1 !secondMatchRequest)
		else $error("second match request while disabled");
	chk_first_gate: assert property (scrWr && !pwdata[0] |=> ##1 !firstMatchRequest)
		else $error("first match request while disabled");
	chk_off_quiet: assert property (scrWr && !pwdata[6] |=> ##2 !(earlyFireA || fireOutA || earlyFireB || fireOutB))
		else $error("fire output while block disabled");
	chk_reset_low: assert property (disable iff (1'b0) rst |=> !(pready || fireOutA || pulsePinOe || wrapRequest))
		else $error("output high after reset");
endmodule // trigger_delay_asserts

bind trigger_delay_block trigger_delay_asserts chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr), .earlyFireA(earlyFireA), .earlyFireB(earlyFireB),
	.fireOutA(fireOutA), .fireOutB(fireOutB), .pulsePinOe(pulsePinOe),
	.wrapRequest(wrapRequest), .firstMatchRequest(firstMatchRequest),
	.secondMatchRequest(secondMatchRequest));

/* File: trigger_source.sv */
/*
 * Trigger source model: raises one trigger line for four clocks on request.
 * Assumes its lines feed fireInput of the block.
 */
`timescale 1ns/100ps
module trigger_source
	import trigger_delay_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       fire,
	input  wire logic [2:0] sel,
	output logic      [6:0] lines
);
	logic [2:0] holdCnt;
	// stretch each request so the input synchroniser sees it
	always_ff @(posedge clk)
	begin
		if (rst)
			holdCnt <= 3'h0;
		else if (fire)
			holdCnt <= 3'h4;
		else if (holdCnt != 3'h0)
			holdCnt <= holdCnt - 3'h1;
	end
	// idle lines rest low like a released logic output
	assign lines = (holdCnt != 3'h0) ? (7'h01 << sel) : 7'h00;
endmodule // trigger_source

/* File: tb.sv */
/*
 * Self-checking bench for the trigger delay block.
 * Assumes the block, its checker and the trigger source model.
 */
`timescale 1ns/100ps
`include "trigger_delay_cfg.svh"
module tb;
	typedef struct packed {logic [2:0] pre; logic [15:0] dA, dB, gap;} row_t;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        fire = 1'b0;
	logic [2:0]  sel = 3'h0;
	logic [31:0] prdata;
	logic [6:0]  fireInput;
	logic        pready, pslverr, earlyFireA, earlyFireB, fireOutA, fireOutB, pulsePinOut;
	logic        pulsePinOe, wrapRequest, firstMatchRequest, secondMatchRequest;
	int          error_cnt = 0, checks = 0, bPulses = 0, pHigh = 0, bBase, pBase;
	// prescale code, delay A, delay B, expected A-to-B gap in clocks
	row_t        rows[4] = '{'{3'h0, 16'h0003, 16'h000A, 16'h0007},
		'{3'h1, 16'h0002, 16'h0005, 16'h0006}, '{3'h3, 16'h0001, 16'h0004, 16'h0018},
		'{3'h7, 16'h0001, 16'h0002, 16'h0080}};
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// count early B pulses and clocks with pulsePinOut high
	always @(posedge clk)
	begin
		if (earlyFireB === 1'b1)
			bPulses <= bPulses + 1;
		if (pulsePinOut === 1'b1)
			pHigh <= pHigh + 1;
	end
	trigger_delay_block #(.TRIG_INPUTS(7)) dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fireInput(fireInput),
		.earlyFireA(earlyFireA), .earlyFireB(earlyFireB), .fireOutA(fireOutA),
		.fireOutB(fireOutB), .pulsePinOut(pulsePinOut), .pulsePinOe(pulsePinOe),
		.wrapRequest(wrapRequest), .firstMatchRequest(firstMatchRequest),
		.secondMatchRequest(secondMatchRequest));
	trigger_source src (.clk(clk), .rst(rst), .fire(fire), .sel(sel), .lines(fireInput));
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		rd = 8'h00;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {6'h00, idx, 2'h0};
		pwdata <= {24'h00_0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1 && n++ < 20);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			print_verdict();
		end
		else
		begin
			rd = prdata[7:0];
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wrReg(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] x;
		apb(1'b1, idx, d, x);
	endtask
	task automatic rdChk(input string what, input logic [3:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		apb(1'b0, idx, 8'h00, x);
		check(what, x, exp);
	endtask
	// clocks until the chosen early fire is seen, bounded
	task automatic waitFire(input logic selB, input int lim, output int cyc);
		cyc = 0;
		do
		begin
			@(posedge clk);
			cyc++;
		end
		while ((selB ? earlyFireB : earlyFireA) !== 1'b1 && cyc < lim);
	endtask
	// main sequence
	initial
	begin
		int cyc;
		logic [7:0] x;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wrReg(`TD_IDX_STATE_EN, 8'h40);
		// ordinary cases: A-to-B gap for prescale codes 0, 1, 3 and 7
		foreach (rows[i])
		begin
			wrReg(`TD_IDX_DLY_A_HIGH, rows[i].dA[15:8]);
			wrReg(`TD_IDX_DLY_A_LOW, rows[i].dA[7:0]);
			wrReg(`TD_IDX_DLY_B_HIGH, rows[i].dB[15:8]);
			wrReg(`TD_IDX_DLY_B_LOW, rows[i].dB[7:0]);
			wrReg(`TD_IDX_SETUP_ONE, 8'h37);
			wrReg(`TD_IDX_SETUP_TWO, {rows[i].pre, 5'h1C});
			wrReg(`TD_IDX_SETUP_TWO, {rows[i].pre, 5'h1D});
			waitFire(1'b0, 300, cyc);
			waitFire(1'b1, 300, cyc);
			check("gap", cyc, rows[i].gap);
		end
		// retrigger mid-count; delay B of zero
		wrReg(`TD_IDX_DLY_A_LOW, 8'h14);
		wrReg(`TD_IDX_DLY_B_LOW, 8'h00);
		wrReg(`TD_IDX_SETUP_ONE, 8'h37);
		wrReg(`TD_IDX_SETUP_TWO, 8'h1D);
		repeat (10) @(posedge clk);
		wrReg(`TD_IDX_SETUP_TWO, 8'h1D);
		waitFire(1'b0, 100, cyc);
		check("restart", cyc > 15 && cyc < 100, 1);
		waitFire(1'b1, 200, cyc);
		check("zero delay", cyc, 200);
		// one-shot round: flags, requests, both-delay and pulse sources
		wrReg(`TD_IDX_DLY_A_LOW, 8'h02);
		wrReg(`TD_IDX_DLY_B_LOW, 8'h03);
		wrReg(`TD_IDX_PERIOD_HIGH, 8'h00);
		wrReg(`TD_IDX_PERIOD_LOW, 8'h06);
		wrReg(`TD_IDX_SETUP_ONE, 8'h5F);
		wrReg(`TD_IDX_STATE_EN, 8'h7F);
		wrReg(`TD_IDX_SETUP_TWO, 8'h1D);
		repeat (2) @(posedge clk);
		bBase = bPulses;
		pBase = pHigh;
		repeat (28) @(posedge clk);
		rdChk("flags set", `TD_IDX_STATE_EN, 8'h7F);
		check("requests", {wrapRequest, secondMatchRequest, firstMatchRequest}, 3'h7);
		check("both delays", bPulses - bBase, 2);
		check("pulse", pHigh - pBase, 1);
		wrReg(`TD_IDX_STATE_EN, 8'h7F);
		repeat (30) @(posedge clk);
		rdChk("flags clear", `TD_IDX_STATE_EN, 8'h55);
		wrReg(`TD_IDX_SETUP_TWO, 8'h1F);
		rdChk("cnt hi", `TD_IDX_COUNT_HIGH, 8'h00);
		rdChk("cnt lo", `TD_IDX_COUNT_LOW, 8'h02);
		wrReg(`TD_IDX_STATE_EN, 8'h7F);
		repeat (30) @(posedge clk);
		rdChk("wraps", `TD_IDX_STATE_EN, 8'h7F);
		// disabled block with pad drive on
		wrReg(`TD_IDX_STATE_EN, 8'h80);
		repeat (2) @(posedge clk);
		check("pad enable", pulsePinOe, 1);
		wrReg(`TD_IDX_SETUP_TWO, 8'h1D);
		waitFire(1'b0, 50, cyc);
		check("disabled", cyc, 50);
		// external input 3 with A bypassed
		wrReg(`TD_IDX_STATE_EN, 8'h40);
		wrReg(`TD_IDX_SETUP_ONE, 8'h02);
		wrReg(`TD_IDX_SETUP_TWO, 8'h0C);
		sel <= 3'h3;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		waitFire(1'b0, 20, cyc);
		check("external", cyc < 20, 1);
		// reset in mid-run, then an unmapped read
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdChk("reset scr", `TD_IDX_STATE_EN, 8'h00);
		rdChk("reset period", `TD_IDX_PERIOD_LOW, 8'hFF);
		rdChk("reset setup", `TD_IDX_SETUP_ONE, 8'h00);
		apb(1'b0, 4'hF, 8'h00, x);
		print_verdict();
	end
endmodule // tb
